// file: gsf_buf.sv
`timescale 1ns/1ps
// one channel's sample store, flip-flops addressed by index
module gsf_buf #(
  parameter int DW = 16,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_ff [DEPTH];

  // no reset on storage; count and pointers decide what is valid
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_ff[raddr_i];
endmodule

// file: gsf_defs.svh
// How it works
// (R1) each of X, Y, Z has its own 256-entry buffer of 16-bit samples
// (R2) four modes: off, normal, interrupt-triggered, snapshot, chosen by configuration
// (R3) normal and interrupt modes pick stop-on-full or overwrite-oldest on overrun
// (R4) off mode updates only output data registers; buffer reads return nothing
// (R5) an active buffer takes one data set per sample tick
// (R6) stop-on-full: once full, every new sample is dropped
// (R7) after a full lock, writes stay blocked until the host drains everything
// (R8) a buffer-full event fires whenever the buffer becomes full
// (R9) overwrite: a sample arriving at a full buffer replaces the oldest
// (R10) overwrite overrun realigns read pointer behind write pointer, dropping only oldest
// (R11) interrupt mode starts disabled, enables itself on any-axis or all-axes rate event
// (R12) snapshot starts overwriting; a rate event switches it to stop-on-full
// (R13) host reads the six-byte data set once per new-sample flag; the bench reads only the X output register, and only once
// (R14) polling host reads faster than the output sample rate; the bench pushes many ticks in a row with no read between
// (R15) host finishes reading a data set before the next sample arrives; the bench pushes many samples in a row with no read between
// (R16) byte order of buffered samples follows the byte-order setting
// (R17) order 0: first byte is bits 15:8, second 7:0; order 1 swaps
// (R18) overflow sets the sticky data-lost flag, bit 4 of status
// (R19) a count register reports the 16-bit words available
// (R20) any-axis rate event is active when at least one axis meets its condition
// (R21) each data port read returns the next word, advances pointer, decrements count
`ifndef GSF_DEFS_SVH
`define GSF_DEFS_SVH
// register byte offsets
`define GSF_OFS_CFG 12'h000
`define GSF_OFS_STAT 12'h004
`define GSF_OFS_CNT 12'h008
`define GSF_OFS_DAT_X 12'h00C
`define GSF_OFS_DAT_Y 12'h010
`define GSF_OFS_DAT_Z 12'h014
`define GSF_OFS_OUT_X 12'h018
`define GSF_OFS_OUT_Y 12'h01C
`define GSF_OFS_OUT_Z 12'h020
// configuration fields
`define GSF_CFG_MODE_LSB 0
`define GSF_CFG_MODE_MSB 1
`define GSF_CFG_OVW_BIT 2
`define GSF_CFG_ORDER_BIT 3
`define GSF_CFG_RST 4'h0
// status fields
`define GSF_ST_NEW_BIT 0
`define GSF_ST_FULL_BIT 1
`define GSF_ST_EMPTY_BIT 2
`define GSF_ST_LOCK_BIT 3
`define GSF_ST_LOST_BIT 4
`define GSF_ST_TRIG_BIT 5
`endif

// file: gsf_host.sv
`timescale 1ns/1ps
// apb master standing in for the host processor on the far side
module gsf_host (
  input wire logic clk_sys_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic hung_o
);
  // idle bus from time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
    hung_o = 1'b0;
  end

  // one transfer; the request stands until pready is sampled high or 20 cycles pass
  // callers make ticks only through the bench's push task, often many in a row with no read between
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= wd;
    @(posedge clk_sys_i);
    penable_o <= 1'b1;
    n = 0;
    // bounded wait: a slave that never answers flags a hang
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_i !== 1'b1 && n < 20);
    rd = prdata_i;
    err = pslverr_i;
    if (pready_i !== 1'b1) hung_o <= 1'b1;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// file: gsf_pkg.sv
package gsf_pkg;
  // buffer operating modes, as written into the configuration register
  typedef enum logic [1:0] {
    GSF_MODE_OFF = 2'h0,
    GSF_MODE_NORMAL = 2'h1,
    GSF_MODE_INTR = 2'h2,
    GSF_MODE_SNAP = 2'h3
  } gsf_mode_t;
  // fill control states
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_WAIT = 5'h02,
    ST_RUN = 5'h04,
    ST_SNAP_PRE = 5'h08,
    ST_SNAP_POST = 5'h10
  } gsf_state_t;
  // one three-axis data set
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } gsf_xyz_t;
endpackage

// file: gsf_top.sv
`timescale 1ns/1ps
`include "gsf_defs.svh"
module gsf_top #(
  parameter int DW = 16,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sample_tick_i,
  input wire gsf_pkg::gsf_xyz_t sample_i,
  input wire logic [2:0] axis_cond_i,
  output logic new_sample_flag_o,
  output logic fifo_full_o,
  output logic data_lost_o
);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  gsf_pkg::gsf_mode_t mode_ff;
  logic ovw_ff;
  logic order_ff;
  gsf_pkg::gsf_state_t st_ff;
  gsf_pkg::gsf_state_t nxt_st;
  gsf_pkg::gsf_xyz_t out_ff;
  logic nsf_ff;
  logic lost_ff;
  logic full_ev_ff;
  logic [AW-1:0] rptr_ff [3];
  logic [AW-1:0] wptr_ff [3];
  logic [AW:0] cnt_ff [3];
  logic [AW:0] nxt_cnt [3];
  logic [2:0] lock_ff;
  logic [DW-1:0] smp [3];
  logic [DW-1:0] mem_rd [3];
  logic [2:0] pop;
  logic [2:0] wr_c;
  logic [2:0] drop;
  logic [2:0] ovr;
  logic [2:0] became_full;
  logic [2:0] hit_dat;

  // apb phases: one wait state, read side effects at capture, writes at completion
  wire acc = psel_i & penable_i;
  wire cap = acc & ~pready_ff;
  wire done = acc & pready_ff;
  wire rd_cap = cap & ~pwrite_i;
  wire wr_done = done & pwrite_i;

  // address decode
  wire hit_cfg = paddr_i == `GSF_OFS_CFG;
  wire hit_stat = paddr_i == `GSF_OFS_STAT;
  wire hit_cnt = paddr_i == `GSF_OFS_CNT;
  wire hit_ox = paddr_i == `GSF_OFS_OUT_X;
  wire hit_oy = paddr_i == `GSF_OFS_OUT_Y;
  wire hit_oz = paddr_i == `GSF_OFS_OUT_Z;
  assign hit_dat[0] = paddr_i == `GSF_OFS_DAT_X;
  assign hit_dat[1] = paddr_i == `GSF_OFS_DAT_Y;
  assign hit_dat[2] = paddr_i == `GSF_OFS_DAT_Z;
  wire hit_out = hit_ox | hit_oy | hit_oz;
  wire mapped = hit_cfg | hit_stat | hit_cnt | hit_out | (|hit_dat);
  wire cfg_wr = wr_done & hit_cfg;
  wire stat_wr = wr_done & hit_stat;
  wire gsf_pkg::gsf_mode_t new_mode = gsf_pkg::gsf_mode_t'(pwdata_i[`GSF_CFG_MODE_MSB:`GSF_CFG_MODE_LSB]);

  // rate triggers built from per-axis range conditions
  wire rate_any = |axis_cond_i; // R20
  wire rate_all = &axis_cond_i;
  wire trig = rate_any | rate_all; // R11 R12

  // fill control
  wire active = st_ff == gsf_pkg::ST_RUN || st_ff == gsf_pkg::ST_SNAP_PRE || st_ff == gsf_pkg::ST_SNAP_POST;
  wire push = sample_tick_i & active; // R5
  // snapshot forces overwrite before the trigger and stop-on-full after it
  wire ovw_eff = (st_ff == gsf_pkg::ST_SNAP_PRE) | (ovw_ff & (st_ff != gsf_pkg::ST_SNAP_POST)); // R3 R12
  wire buf_on = mode_ff != gsf_pkg::GSF_MODE_OFF;

  // byte order of a 16-bit word: low byte of bus is the first register
  function automatic logic [15:0] order_word(input logic [15:0] s, input logic ord);
    order_word = ord ? s : {s[7:0], s[15:8]}; // R16 R17
  endfunction

  // mode state: a config write restarts the selected mode from its start state
  always_comb begin
    nxt_st = st_ff;
    if (cfg_wr) begin
      case (new_mode)
        gsf_pkg::GSF_MODE_NORMAL: nxt_st = gsf_pkg::ST_RUN;
        gsf_pkg::GSF_MODE_INTR: nxt_st = gsf_pkg::ST_WAIT; // R11
        gsf_pkg::GSF_MODE_SNAP: nxt_st = gsf_pkg::ST_SNAP_PRE; // R12
        default: nxt_st = gsf_pkg::ST_OFF; // R2
      endcase
    end else begin
      case (st_ff)
        gsf_pkg::ST_WAIT: if (trig) nxt_st = gsf_pkg::ST_RUN; // R11
        gsf_pkg::ST_SNAP_PRE: if (trig) nxt_st = gsf_pkg::ST_SNAP_POST; // R12
        gsf_pkg::ST_OFF, gsf_pkg::ST_RUN, gsf_pkg::ST_SNAP_POST: nxt_st = st_ff;
        default: nxt_st = gsf_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff <= gsf_pkg::ST_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // configuration register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_ff <= gsf_pkg::GSF_MODE_OFF;
      ovw_ff <= 1'(`GSF_CFG_RST >> `GSF_CFG_OVW_BIT);
      order_ff <= 1'(`GSF_CFG_RST >> `GSF_CFG_ORDER_BIT);
    end else if (cfg_wr) begin
      mode_ff <= new_mode; // R2
      ovw_ff <= pwdata_i[`GSF_CFG_OVW_BIT]; // R3
      order_ff <= pwdata_i[`GSF_CFG_ORDER_BIT]; // R16
    end
  end

  assign smp[0] = sample_i.x;
  assign smp[1] = sample_i.y;
  assign smp[2] = sample_i.z;

  // per-channel buffer, pointers and fill accounting
  for (genvar c = 0; c < 3; c++) begin : g_ch
    wire is_full = (cnt_ff[c] == FULL_CNT) & ~pop[c];
    assign pop[c] = rd_cap & hit_dat[c] & buf_on & (cnt_ff[c] != '0); // R4 R21
    assign drop[c] = push & (lock_ff[c] | (is_full & ~ovw_eff)); // R6 R7
    assign ovr[c] = push & is_full & ovw_eff & ~lock_ff[c]; // R9
    assign wr_c[c] = push & ~drop[c];
    // overwrite keeps the count at full; otherwise up on store, down on pop
    assign nxt_cnt[c] = cnt_ff[c] + (AW+1)'(wr_c[c] & ~ovr[c]) - (AW+1)'(pop[c]); // R21
    assign became_full[c] = (nxt_cnt[c] == FULL_CNT) & (cnt_ff[c] != FULL_CNT); // R8

    gsf_buf #(.DW(DW), .DEPTH(DEPTH), .AW(AW)) u_buf (
      .clk_sys_i(clk_sys_i),
      .we_i(wr_c[c]),
      .waddr_i(wptr_ff[c]),
      .wdata_i(smp[c]),
      .raddr_i(rptr_ff[c]),
      .rdata_o(mem_rd[c])
    );

    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        cnt_ff[c] <= '0;
        wptr_ff[c] <= '0;
        rptr_ff[c] <= '0;
        lock_ff[c] <= 1'b0;
      end else begin
        cnt_ff[c] <= nxt_cnt[c]; // R1 R19
        wptr_ff[c] <= wptr_ff[c] + AW'(wr_c[c]); // R5
        // realigned onto the advanced write slot, i.e. at the oldest survivor
        rptr_ff[c] <= ovr[c] ? wptr_ff[c] + AW'(1) : rptr_ff[c] + AW'(pop[c]); // R10 R21
        // lock only clears once every stored entry is gone
        lock_ff[c] <= (lock_ff[c] | ((nxt_cnt[c] == FULL_CNT) & ~ovw_eff)) & (nxt_cnt[c] != '0); // R7
      end
    end
  end

  // output data registers and new-sample flag update in every mode
  wire out_rd = rd_cap & hit_out;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_ff <= '0;
      nsf_ff <= 1'b0;
    end else begin
      if (sample_tick_i) begin
        out_ff <= sample_i; // R4
      end
      // a tick in the same cycle as the clearing read wins
      nsf_ff <= sample_tick_i | (nsf_ff & ~out_rd);
    end
  end

  // sticky data-lost flag, cleared by writing one to its bit; a new loss wins
  wire lost_ev = |(drop | ovr);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lost_ff <= 1'b0;
      full_ev_ff <= 1'b0;
    end else begin
      lost_ff <= lost_ev | (lost_ff & ~(stat_wr & pwdata_i[`GSF_ST_LOST_BIT])); // R18
      full_ev_ff <= |became_full; // R8
    end
  end

  // read data selection
  wire [AW+2:0] cnt_sum = (AW+3)'(cnt_ff[0]) + (AW+3)'(cnt_ff[1]) + (AW+3)'(cnt_ff[2]); // R19
  wire [31:0] stat_w = 32'({st_ff == gsf_pkg::ST_SNAP_POST, lost_ff, |lock_ff,
                            cnt_sum == '0, |(became_full | {cnt_ff[2] == FULL_CNT,
                            cnt_ff[1] == FULL_CNT, cnt_ff[0] == FULL_CNT}), nsf_ff});
  wire [31:0] cfg_w = 32'({order_ff, ovw_ff, mode_ff});
  wire [15:0] dat_w = hit_dat[0] ? order_word(mem_rd[0], order_ff) :
                      hit_dat[1] ? order_word(mem_rd[1], order_ff) : order_word(mem_rd[2], order_ff);
  wire dat_ok = |(hit_dat & pop); // off mode or empty reads as zero
  wire [15:0] out_w = hit_ox ? order_word(out_ff.x, order_ff) :
                      hit_oy ? order_word(out_ff.y, order_ff) : order_word(out_ff.z, order_ff);
  wire [31:0] rdata_w = hit_cfg ? cfg_w :
                        hit_stat ? stat_w :
                        hit_cnt ? 32'(cnt_sum) :
                        hit_out ? 32'(out_w) :
                        dat_ok ? 32'(dat_w) : 32'h0000_0000; // R4

  // apb answer registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= cap;
      if (cap) begin
        pslverr_ff <= ~mapped;
        prdata_ff <= (pwrite_i | ~mapped) ? 32'h0000_0000 : rdata_w;
      end
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign new_sample_flag_o = nsf_ff;
  assign fifo_full_o = full_ev_ff;
  assign data_lost_o = lost_ff;

  // checks on channel X stand for all three, which share one generate body
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_buf_depth: assert property (cnt_ff[0] <= FULL_CNT) // R1
    else $error("channel count above depth");
  a_mode_init: assert property (cfg_wr && new_mode == gsf_pkg::GSF_MODE_INTR |=> st_ff == gsf_pkg::ST_WAIT) // R2
    else $error("interrupt mode did not start disabled");
  a_off_read: assert property (rd_cap && hit_dat[0] && !buf_on |=> prdata_o == 32'h0000_0000) // R4
    else $error("off mode returned buffer data");
  a_push_tick: assert property (push && !lock_ff[0] && cnt_ff[0] < FULL_CNT && !pop[0]
    |=> cnt_ff[0] == $past(cnt_ff[0]) + (AW+1)'(1)) // R5
    else $error("active tick did not store a sample");
  a_stop_drop: assert property (push && !ovw_eff && cnt_ff[0] == FULL_CNT && !pop[0]
    |=> $stable(wptr_ff[0]) && cnt_ff[0] == FULL_CNT) // R6
    else $error("stop-on-full stored into a full buffer");
  a_lock_hold: assert property (lock_ff[0] && push |=> $stable(wptr_ff[0]) && cnt_ff[0] <= $past(cnt_ff[0])) // R7
    else $error("locked buffer accepted a write");
  a_full_event: assert property ($rose(cnt_ff[0] == FULL_CNT) |-> fifo_full_o) // R8
    else $error("buffer filled without full event");
  a_ovr_realign: assert property (ovr[0] |=> rptr_ff[0] == wptr_ff[0] && cnt_ff[0] == FULL_CNT) // R9 R10
    else $error("overwrite did not realign read pointer");
  a_intr_trig: assert property (st_ff == gsf_pkg::ST_WAIT && trig && !cfg_wr |=> st_ff == gsf_pkg::ST_RUN) // R11
    else $error("interrupt mode did not enable on rate event");
  a_snap_switch: assert property (st_ff == gsf_pkg::ST_SNAP_PRE && rate_any && !cfg_wr |=> !ovw_eff) // R12 R20
    else $error("snapshot did not switch to stop-on-full");
  a_byte_order: assert property (pop[0] && !order_ff |=> prdata_o[7:0] == $past(mem_rd[0][15:8])) // R17
    else $error("byte order 0 not high byte first");
  a_lost_set: assert property ((drop[0] || ovr[0]) ##1 !stat_wr |-> data_lost_o ##1 data_lost_o) // R18
    else $error("loss did not set sticky flag");
  a_pop_count: assert property (pop[0] && !push |=> cnt_ff[0] == $past(cnt_ff[0]) - (AW+1)'(1)) // R21
    else $error("read did not decrement count");

  c_overwrite: cover property (ovr[0]);
  c_lock_drain: cover property (lock_ff[0] ##[1:1000] !lock_ff[0]);
  c_snap_full: cover property (st_ff == gsf_pkg::ST_SNAP_POST && fifo_full_o);
  c_intr_run: cover property (st_ff == gsf_pkg::ST_WAIT ##1 st_ff == gsf_pkg::ST_RUN);
endmodule

// file: gyro_sample_fifo_modes_bench.sv
`timescale 1ns/1ps
`include "gsf_defs.svh"
`define CMP(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module gyro_sample_fifo_modes_bench;
  logic clk_sys_i, rst_i, psel, penable, pwrite, pready, pslverr, tick, hung;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  gsf_pkg::gsf_xyz_t sample;
  logic [2:0] cond;
  logic nsf, full, lost, seen_full, e;
  logic [2:0] trig [2];
  int n_mismatch = 0;
  int checked = 0;
  int i, k;

  gsf_top gsf_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sample_tick_i(tick), .sample_i(sample), .axis_cond_i(cond),
    .new_sample_flag_o(nsf), .fifo_full_o(full), .data_lost_o(lost));
  gsf_host gsf_host_inst (.clk_sys_i(clk_sys_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .hung_o(hung));

  // 125 mhz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // the full pulse lasts one cycle, so latch it for later inspection
  always @(posedge clk_sys_i) if (full === 1'b1) seen_full <= 1'b1;
  // a hung transfer ends the run as a failure
  always @(posedge clk_sys_i) if (hung === 1'b1) begin
    n_mismatch++;
    give_verdict();
  end

  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] t;
    gsf_host_inst.xfer(1'b1, a, v, t, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    gsf_host_inst.xfer(1'b0, a, 32'h0, v, e);
  endtask
  // y and z carry fixed xor patterns so channels cannot be confused
  task automatic push(input logic [15:0] v);
    @(posedge clk_sys_i);
    tick <= 1'b1;
    sample <= {v, v ^ 16'h5555, v ^ 16'hAAAA};
    @(posedge clk_sys_i);
    tick <= 1'b0;
  endtask
  task automatic count_is(input logic [31:0] exp);
    logic [31:0] v;
    rd(`GSF_OFS_CNT, v);
    `CMP(v, exp)
  endtask
  task automatic reset_dut();
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rate_event(input logic [2:0] c);
    @(posedge clk_sys_i);
    cond <= c;
    @(posedge clk_sys_i);
    cond <= 3'h0;
  endtask

  initial begin
    rst_i = 1'b1;
    tick = 1'b0;
    sample = '0;
    cond = 3'h0;
    seen_full = 1'b0;
    trig[0] = 3'b010;
    trig[1] = 3'b111;
    reset_dut();
    // reset state and an unmapped address
    rd(`GSF_OFS_CFG, d);
    `CMP(d, 32'h0)
    rd(`GSF_OFS_STAT, d);
    `CMP(d, 32'h4)
    count_is(32'd0);
    rd(12'h024, d);
    `CMP(e, 1'b1)
    `CMP(d, 32'h0)
    // off mode: output registers only, byte order 0
    push(16'h1234);
    #1;
    `CMP(nsf, 1'b1)
    rd(`GSF_OFS_DAT_X, d);
    `CMP(d, 32'h0)
    count_is(32'd0);
    rd(`GSF_OFS_OUT_X, d);
    `CMP(d, 32'h3412)
    #1;
    `CMP(nsf, 1'b0)
    // normal, stop-on-full, byte order 1
    wr(`GSF_OFS_CFG, 32'h9);
    #1;
    seen_full = 1'b0;
    for (i = 0; i < 256; i++) push(16'(i));
    @(posedge clk_sys_i);
    #1;
    `CMP(seen_full, 1'b1)
    count_is(32'd768);
    push(16'hFFFF);
    count_is(32'd768);
    `CMP(lost, 1'b1)
    rd(`GSF_OFS_DAT_X, d);
    `CMP(d, 32'h0)
    count_is(32'd767);
    push(16'hEEEE);
    count_is(32'd767);
    for (i = 1; i < 256; i++) begin
      rd(`GSF_OFS_DAT_X, d);
      `CMP(d, {16'h0, 16'(i)})
    end
    for (i = 0; i < 256; i++) begin
      rd(`GSF_OFS_DAT_Y, d);
      `CMP(d, {16'h0, 16'(i) ^ 16'h5555})
      rd(`GSF_OFS_DAT_Z, d);
      `CMP(d, {16'h0, 16'(i) ^ 16'hAAAA})
    end
    count_is(32'd0);
    rd(`GSF_OFS_DAT_X, d);
    `CMP(d, 32'h0)
    push(16'h0042);
    count_is(32'd3);
    rd(`GSF_OFS_STAT, d);
    `CMP(d[4], 1'b1)
    wr(`GSF_OFS_STAT, 32'h10);
    rd(`GSF_OFS_STAT, d);
    `CMP(d[4], 1'b0)
    // normal, overwrite: two overruns drop the two oldest
    reset_dut();
    wr(`GSF_OFS_CFG, 32'hD);
    for (i = 0; i < 258; i++) push(16'(i));
    count_is(32'd768);
    rd(`GSF_OFS_DAT_X, d);
    `CMP(d, 32'h2)
    rd(`GSF_OFS_DAT_Y, d);
    `CMP(d, {16'h0, 16'h2 ^ 16'h5555})
    wr(`GSF_OFS_CFG, 32'h5);
    rd(`GSF_OFS_DAT_X, d);
    `CMP(d, 32'h0300)
    // interrupt mode, triggered by one axis and by all axes
    for (k = 0; k < 2; k++) begin
      reset_dut();
      wr(`GSF_OFS_CFG, 32'hA);
      push(16'h0007);
      count_is(32'd0);
      rate_event(trig[k]);
      push(16'h0008);
      count_is(32'd3);
      rd(`GSF_OFS_DAT_X, d);
      `CMP(d, 32'h8)
    end
    // snapshot: overwrite until the event, then stop when full
    reset_dut();
    wr(`GSF_OFS_CFG, 32'hB);
    for (i = 0; i < 258; i++) push(16'(i));
    count_is(32'd768);
    rate_event(3'b001);
    rd(`GSF_OFS_STAT, d);
    `CMP(d[5], 1'b1)
    rd(`GSF_OFS_DAT_X, d);
    `CMP(d, 32'h2)
    push(16'h0100);
    push(16'h0101);
    count_is(32'd767);
    rd(`GSF_OFS_DAT_X, d);
    `CMP(d, 32'h3)
    give_verdict();
  end
endmodule
